// file: rtl/spc_marker_insert.sv
// Purpose: packs a converter sample into the link field with an optional marker
// Assumes: sample_i is already one stage behind the pins
// Notes:   the marker travels a pipeline matched to the sample latency
`timescale 1ns/10ps
module spc_marker_insert
  import spc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              hold_i,
  input  wire logic              enable_i,
  input  wire logic              marker_i,
  input  wire logic [CONV_W-1:0] sample_i,
  output logic [LINK_N-1:0]      link_o
);

  logic [SAMPLE_LAT-2:0] mk_q;
  logic [LINK_N-1:0]     field;

  // marker sees the same stage count as the samples, pin to output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mk_q <= '0;
    end else begin
      mk_q[0] <= marker_i;
      for (int k = 1; k < SAMPLE_LAT - 1; k++) begin
        mk_q[k] <= mk_q[k-1];
      end
    end
  end

  // wide field keeps all data bits, narrow field gives up the data lsb
  generate
    if (LINK_N > CONV_W) begin : g_wide
      assign field = {sample_i, {(LINK_N-CONV_W-1){1'b0}},
                      enable_i & mk_q[SAMPLE_LAT-2]};
    end else begin : g_narrow
      assign field = {sample_i[CONV_W-1:1], enable_i & mk_q[SAMPLE_LAT-2]};
    end
  endgenerate

  // output stage, cleared while the link block is held off
  always_ff @(posedge clk_i) begin
    if (rst_i || hold_i) begin
      link_o <= '0;
    end else begin
      link_o <= field;
    end
  end

endmodule

// file: rtl/spc_pkg.sv
// Purpose: shared constants for the sample path configuration block
// Assumes: registers are 8 bits wide, one per 32-bit bus word
// Notes:   byte address of a register is four times its index
package spc_pkg;

  // bus geometry
  localparam int unsigned WB_AW    = 12;
  localparam int unsigned WB_DW    = 32;
  localparam int unsigned WB_SW    = 4;
  localparam int unsigned IDX_W    = 10;
  localparam int unsigned REG_W    = 8;

  // register indices, byte address = index * 4
  localparam logic [IDX_W-1:0] IDX_STEER  = 10'h09B;
  localparam logic [IDX_W-1:0] IDX_DITHER = 10'h09D;
  localparam logic [IDX_W-1:0] IDX_MARKER = 10'h160;
  localparam logic [IDX_W-1:0] IDX_LINK   = 10'h200;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h210;

  // field layout
  localparam int unsigned STEER_W      = 5;
  localparam int unsigned DITH_W       = 3;
  localparam int unsigned DITH_EN_BIT  = 0;
  localparam int unsigned DITH_AMP_BIT = 1;
  localparam int unsigned DITH_ERR_BIT = 2;
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_SEL     = 1;
  localparam int unsigned STAT_DLY_LSB = 2;

  // reset values
  localparam logic [STEER_W-1:0] RST_STEER  = 5'h07;
  localparam logic [DITH_W-1:0]  RST_DITHER = 3'h0;
  localparam logic               RST_MARKER = 1'h0;
  localparam logic               RST_LINK   = 1'h1;

  // sample path geometry
  localparam int unsigned STEER_DEPTH = 32;
  localparam int unsigned CONV_W      = 9;
  localparam int unsigned LINK_N      = 12;
  localparam int unsigned CS_W        = 2;
  localparam logic [CS_W-1:0] ILA_CS  = 2'h0;
  localparam int unsigned SAMPLE_LAT  = 2;

  // swap tracking states
  typedef enum logic [1:0] {
    SPC_ST_IDLE = 2'b01,
    SPC_ST_SWAP = 2'b10
  } spc_swap_st_t;

endpackage

// file: rtl/spc_steer_delay.sv
// Purpose: delays the core select signal by a programmed count during swaps
// Assumes: swap_active_i is high for the whole background swap
// Notes:   the delay is frozen at swap start and reloaded only between swaps
`timescale 1ns/10ps
module spc_steer_delay
  import spc_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               swap_active_i,
  input  wire logic               sel_i,
  input  wire logic [STEER_W-1:0] delay_i,
  output logic                    sel_o,
  output logic                    busy_o,
  output logic [STEER_W-1:0]      delay_used_o
);

  spc_swap_st_t           st_q;
  logic [STEER_DEPTH-1:0] hist_q;
  logic [STEER_DEPTH-1:0] taps;

  // tap k is the select as it stood k cycles ago, tap 0 is the live value
  assign taps = {hist_q[STEER_DEPTH-2:0], sel_i};

  // select history, one cycle per stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hist_q <= '0;
    end else begin
      hist_q <= taps;
    end
  end

  // swap tracking; delay latched on entry so a rewrite cannot tear a swap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q         <= SPC_ST_IDLE;
      delay_used_o <= RST_STEER;
    end else begin
      unique case (st_q)
        SPC_ST_IDLE: begin
          delay_used_o <= delay_i;
          if (swap_active_i) begin
            st_q <= SPC_ST_SWAP;
          end
        end
        SPC_ST_SWAP: begin
          if (!swap_active_i) begin
            st_q <= SPC_ST_IDLE;
          end
        end
        default: st_q <= SPC_ST_IDLE;
      endcase
    end
  end

  // delayed tap only inside a swap, live select otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_o  <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      busy_o <= (st_q == SPC_ST_SWAP);
      if (st_q == SPC_ST_SWAP) begin
        sel_o <= taps[delay_used_o];
      end else begin
        sel_o <= sel_i;
      end
    end
  end

endmodule

// file: rtl/spc_top.sv
// Purpose: configuration registers and sample steering for the converter path
// Assumes: classic Wishbone slave, 8-bit registers in byte lane 0
// Notes:   every output comes from a flip-flop; reserved bits read as zero
//
// Overview of operation
// - five-bit steering delay in bits 4:0, reset value 0x07.
// - delay applies only during background swaps, select untouched otherwise.
// - any delay value from 0 to 31 is accepted.
// - delayed select steers core samples into the link encoders.
// - dither register bit 0 enables dither, resets to 0.
// - dither bit 1 picks amplitude: 0 small, 1 large.
// - dither bit 2 sends rounding error to noise (0) or offset/spurs (1).
// - marker bit 0 puts the timestamp input in each sample lsb.
// - with a wider link field, marker uses field lsb, data intact.
// - link subsystem enable register resets to 0x01.
// - enable low holds link in reset, serializers down, clocks gated.
`timescale 1ns/10ps
module spc_top
  import spc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [WB_AW-1:0]  wb_adr_i,
  input  wire logic [WB_SW-1:0]  wb_sel_i,
  input  wire logic [WB_DW-1:0]  wb_dat_i,
  output logic [WB_DW-1:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              swap_active_i,
  input  wire logic              core_sel_i,
  input  wire logic [CONV_W-1:0] core_a_sample_i,
  input  wire logic [CONV_W-1:0] core_b_sample_i,
  input  wire logic              marker_i,
  output logic                   mux_sel_o,
  output logic [LINK_N-1:0]      link_sample_o,
  output logic                   dither_enable_o,
  output logic                   dither_amplitude_select_o,
  output logic                   dither_rounding_select_o,
  output logic                   marker_insert_enable_o,
  output logic                   link_reset_o,
  output logic                   serializer_powerdown_o,
  output logic                   link_clock_gate_o,
  output logic                   multiframe_reset_o,
  output logic [CS_W-1:0]        ila_cs_o
);

  // register state
  logic [STEER_W-1:0] steer_q;
  logic [DITH_W-1:0]  dith_q;
  logic               marker_en_q;
  logic               link_en_q;
  logic               link_hold_q;

  // bus decode
  logic [IDX_W-1:0]   idx;
  logic               req;
  logic               wr;
  logic               rd;
  logic [REG_W-1:0]   rdata;

  // steering path
  logic               steer_sel;
  logic               steer_busy;
  logic [STEER_W-1:0] steer_used;
  logic [CONV_W-1:0]  sample_q;

  // register index match, used by both the write and the read decode
  function automatic logic spc_hit(input logic [IDX_W-1:0] a,
                                   input logic [IDX_W-1:0] r);
    spc_hit = (a == r);
  endfunction

  // word index; the two lowest address bits select a byte and are ignored
  assign idx = wb_adr_i[WB_AW-1:2];
  assign req = wb_cyc_i & wb_stb_i;

  // writes land on the edge where ack is seen high by the master
  assign wr  = req & wb_we_i & wb_ack_o & wb_sel_i[0];
  // read data is captured on the edge that raises ack
  assign rd  = req & ~wb_we_i & ~wb_ack_o;

  // single wait state answer; ack drops the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  // steering delay register, full 0 to 31 range stored as written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      steer_q <= RST_STEER;
    end else if (wr && spc_hit(idx, IDX_STEER)) begin
      steer_q <= wb_dat_i[STEER_W-1:0];
    end
  end

  // dither control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dith_q <= RST_DITHER;
    end else if (wr && spc_hit(idx, IDX_DITHER)) begin
      dith_q <= wb_dat_i[DITH_W-1:0];
    end
  end

  // marker insertion control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      marker_en_q <= RST_MARKER;
    end else if (wr && spc_hit(idx, IDX_MARKER)) begin
      marker_en_q <= wb_dat_i[0];
    end
  end

  // link subsystem enable, on out of reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_en_q <= RST_LINK;
    end else if (wr && spc_hit(idx, IDX_LINK)) begin
      link_en_q <= wb_dat_i[0];
    end
  end

  // read mux; reserved and unmapped locations return zero
  always_comb begin
    rdata = '0;
    if (spc_hit(idx, IDX_STEER)) begin
      rdata[STEER_W-1:0] = steer_q;
    end else if (spc_hit(idx, IDX_DITHER)) begin
      rdata[DITH_W-1:0] = dith_q;
    end else if (spc_hit(idx, IDX_MARKER)) begin
      rdata[0] = marker_en_q;
    end else if (spc_hit(idx, IDX_LINK)) begin
      rdata[0] = link_en_q;
    end else if (spc_hit(idx, IDX_STATUS)) begin
      rdata[STAT_BUSY] = steer_busy;
      rdata[STAT_SEL]  = mux_sel_o;
      rdata[STAT_DLY_LSB +: STEER_W] = steer_used;
    end
  end

  // read data register, held until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (rd) begin
      wb_dat_o <= {{(WB_DW-REG_W){1'b0}}, rdata};
    end
  end

  // converter dither controls and marker insert enable, one flop stage behind the registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dither_enable_o           <= 1'b0;
      dither_amplitude_select_o <= 1'b0;
      dither_rounding_select_o  <= 1'b0;
      marker_insert_enable_o    <= 1'b0;
    end else begin
      dither_enable_o           <= dith_q[DITH_EN_BIT];
      dither_amplitude_select_o <= dith_q[DITH_AMP_BIT];
      dither_rounding_select_o  <= dith_q[DITH_ERR_BIT];
      marker_insert_enable_o    <= marker_en_q;
    end
  end

  // link hold; one flop feeds all four so they always move together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_hold_q <= ~RST_LINK;
    end else begin
      link_hold_q <= ~link_en_q;
    end
  end

  assign link_reset_o           = link_hold_q;
  assign serializer_powerdown_o = link_hold_q;
  assign link_clock_gate_o      = link_hold_q;
  assign multiframe_reset_o     = link_hold_q;

  // control bit count is never advertised, whatever the marker setting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ila_cs_o <= ILA_CS;
    end else begin
      ila_cs_o <= ILA_CS;
    end
  end

  // select delay line for background swaps
  spc_steer_delay u_steer (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .swap_active_i (swap_active_i),
    .sel_i         (core_sel_i),
    .delay_i       (steer_q),
    .sel_o         (steer_sel),
    .busy_o        (steer_busy),
    .delay_used_o  (steer_used)
  );

  assign mux_sel_o = steer_sel;

  // encoder input mux driven by the delayed select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_q <= '0;
    end else begin
      sample_q <= steer_sel ? core_b_sample_i : core_a_sample_i;
    end
  end

  // pack into the link field and add the marker
  spc_marker_insert u_marker (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .hold_i   (link_hold_q),
    .enable_i (marker_en_q),
    .marker_i (marker_i),
    .sample_i (sample_q),
    .link_o   (link_sample_o)
  );

endmodule

// file: verification/spc_top_props.sv
// Purpose: concurrent checks on the sample path configuration ports
// Assumes: one clock domain, synchronous active high reset
// Notes:   swap delay lengths are measured by the bench, not here
`timescale 1ns/10ps
module spc_top_props
  import spc_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  input wire logic              swap_active_i,
  input wire logic              core_sel_i,
  input wire logic [CONV_W-1:0] core_a_sample_i,
  input wire logic [CONV_W-1:0] core_b_sample_i,
  input wire logic              marker_i,
  input wire logic              mux_sel_o,
  input wire logic [LINK_N-1:0] link_sample_o,
  input wire logic              marker_insert_enable_o,
  input wire logic              link_reset_o,
  input wire logic              serializer_powerdown_o,
  input wire logic              link_clock_gate_o,
  input wire logic              multiframe_reset_o,
  input wire logic [CS_W-1:0]   ila_cs_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [CONV_W-1:0] pick_w;
  logic              sel_prev_q;
  logic [2:0]        quiet_q;
  // data the live select picks, compared two edges later
  assign pick_w = core_sel_i ? core_b_sample_i : core_a_sample_i;
  // previous select, to see when it moves
  always_ff @(posedge clk_i) begin
    sel_prev_q <= core_sel_i;
  end
  // calm cycles: a moving select or swap would make the data check guess
  always_ff @(posedge clk_i) begin
    if (rst_i || swap_active_i || link_reset_o || core_sel_i != sel_prev_q)
      quiet_q <= 3'h0;
    else if (quiet_q != 3'h7)
      quiet_q <= quiet_q + 3'h1;
  end
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_HOLD_EQUAL: assert property (link_reset_o == serializer_powerdown_o &&
    link_reset_o == link_clock_gate_o && link_reset_o == multiframe_reset_o)
    else $error("link hold outputs disagree");
  AST_HOLD_ZERO: assert property (link_reset_o [*2] |-> link_sample_o == 12'h000)
    else $error("samples leave a held link");
  AST_ILA_CS: assert property (ila_cs_o == ILA_CS)
    else $error("alignment control bit count not zero");
  AST_IDLE_SEL: assert property ((!swap_active_i) [*3] |=> mux_sel_o == $past(core_sel_i))
    else $error("select delayed outside a swap");
  AST_MARKER: assert property ((!link_reset_o && $stable(marker_insert_enable_o)) [*3]
    |-> link_sample_o[0] == ($past(marker_i, 2) & marker_insert_enable_o))
    else $error("marker bit wrong or misaligned");
  AST_PAD_ZERO: assert property (link_sample_o[2:1] == 2'h0)
    else $error("pad bits of link field not zero");
  AST_DATA: assert property (quiet_q >= 3'h4 |-> link_sample_o[11:3] == $past(pick_w, 2))
    else $error("link data not from selected core");
endmodule
bind spc_top spc_top_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .swap_active_i(swap_active_i),
  .core_sel_i(core_sel_i), .core_a_sample_i(core_a_sample_i),
  .core_b_sample_i(core_b_sample_i), .marker_i(marker_i), .mux_sel_o(mux_sel_o),
  .link_sample_o(link_sample_o), .marker_insert_enable_o(marker_insert_enable_o),
  .link_reset_o(link_reset_o), .serializer_powerdown_o(serializer_powerdown_o),
  .link_clock_gate_o(link_clock_gate_o), .multiframe_reset_o(multiframe_reset_o),
  .ila_cs_o(ila_cs_o));

// file: verification/test_spc_top.sv
// Purpose: self-checking bench for the sample path configuration block
// Assumes: classic single-cycle bus master, one 250 MHz clock
// Notes:   select lag is counted in edges from a flip to the applied select
`timescale 1ns/10ps
module test_spc_top
  import spc_pkg::*;
;
  logic              clk_i = 1'h0;
  logic              rst_i = 1'h1;
  logic              wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [WB_AW-1:0]  wb_adr_i;
  logic [WB_SW-1:0]  wb_sel_i;
  logic [WB_DW-1:0]  wb_dat_i, wb_dat_o, rd;
  logic              swap_active_i, core_sel_i, marker_i, mux_sel_o;
  logic [CONV_W-1:0] core_a_sample_i, core_b_sample_i;
  logic [LINK_N-1:0] link_sample_o;
  logic              dither_enable_o, dither_amplitude_select_o, dither_rounding_select_o;
  logic              marker_insert_enable_o, link_reset_o, serializer_powerdown_o;
  logic              link_clock_gate_o, multiframe_reset_o;
  logic [CS_W-1:0]   ila_cs_o;
  int                err_total, samples_checked;
  spc_top uut (.*);
  // 4 ns period
  always #2 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one classic cycle, entered just after an edge; data is taken at the ack edge
  task automatic bus(input logic we, input logic [IDX_W-1:0] ix, input logic [7:0] d,
                     input logic s0 = 1'h1);
    int n;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= {ix, 2'h0};
    wb_sel_i <= s0 ? 4'hF : 4'hE;
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (wb_ack_o !== 1'h1) begin
      err_total++;
      conclude();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i  <= 1'h0;
    @(posedge clk_i);
  endtask
  // reset values of all four registers and the idle link reset output
  task automatic t_reset();
    logic [IDX_W-1:0] ix [4] = '{IDX_STEER, IDX_DITHER, IDX_MARKER, IDX_LINK};
    logic [7:0]       rv [4] = '{8'h07, 8'h00, 8'h00, 8'h01};
    for (int i = 0; i < 4; i++) begin
      bus(1'h0, ix[i], 8'h00);
      chk(rd, {24'h0, rv[i]});
    end
    chk(32'(link_reset_o), 32'h0);
  endtask
  // each dither field alone, top of the delay range, a lane-masked write and an unmapped read
  task automatic t_regs();
    for (int b = 0; b < 3; b++) begin
      bus(1'h1, IDX_DITHER, 8'h01 << b);
      @(posedge clk_i);
      chk(32'({dither_rounding_select_o, dither_amplitude_select_o, dither_enable_o}),
          32'h1 << b);
      bus(1'h0, IDX_DITHER, 8'h00);
      chk(rd, 32'h1 << b);
    end
    bus(1'h1, IDX_DITHER, 8'h00);
    bus(1'h1, IDX_STEER, 8'h1F);
    bus(1'h1, IDX_STEER, 8'h03, 1'h0);
    bus(1'h0, IDX_STEER, 8'h00);
    chk(rd, 32'h1F);
    bus(1'h0, 10'h3FF, 8'h00);
    chk(rd, 32'h0);
  endtask
  // clearing the enable holds the link and blanks the samples
  task automatic t_link();
    bus(1'h1, IDX_LINK, 8'h00);
    repeat (2) @(posedge clk_i);
    chk(32'({link_reset_o, serializer_powerdown_o, link_clock_gate_o, multiframe_reset_o}),
        32'hF);
    chk(32'(link_sample_o), 32'h0);
    bus(1'h1, IDX_LINK, 8'h01);
    @(posedge clk_i);
    chk(32'(link_reset_o), 32'h0);
  endtask
  // marker at the field lsb beside intact data from the chosen core
  task automatic t_marker();
    bus(1'h1, IDX_MARKER, 8'h01);
    // the enable output trails the register by one flop stage
    @(posedge clk_i);
    chk(32'(marker_insert_enable_o), 32'h1);
    for (int m = 0; m < 2; m++) begin
      marker_i <= m[0];
      repeat (3) @(posedge clk_i);
      chk(32'(link_sample_o), {20'h0, core_a_sample_i, 2'h0, m[0]});
    end
    core_sel_i <= 1'h1;
    repeat (5) @(posedge clk_i);
    chk(32'(link_sample_o[11:3]), 32'(core_b_sample_i));
    bus(1'h1, IDX_MARKER, 8'h00);
    repeat (3) @(posedge clk_i);
    chk(32'(link_sample_o[0]), 32'h0);
  endtask
  // flips the raw select and counts edges until the applied select follows
  task automatic lag(input int exp);
    int n;
    core_sel_i <= ~core_sel_i;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (mux_sel_o !== core_sel_i && n < 40);
    chk(32'(n), 32'(exp));
    if (n >= 40) conclude();
  endtask
  // delay counts 0, 5 and 31 inside a swap; a write mid-swap waits its turn
  task automatic t_swap();
    logic [7:0] dl [3] = '{8'h00, 8'h05, 8'h1F};
    lag(2);
    for (int i = 0; i < 3; i++) begin
      bus(1'h1, IDX_STEER, dl[i]);
      swap_active_i <= 1'h1;
      // let the select history settle past the tap in use, or an old flip shows early
      repeat (int'(dl[i]) + 3) @(posedge clk_i);
      lag(int'(dl[i]) + 2);
      bus(1'h1, IDX_STEER, 8'h02);
      lag(int'(dl[i]) + 2);
      bus(1'h0, IDX_STATUS, 8'h00);
      chk(32'(rd[6:2]), 32'(dl[i]));
      chk(32'(rd[0]), 32'h1);
      chk(32'(rd[1]), 32'(core_sel_i));
      swap_active_i <= 1'h0;
      repeat (3) @(posedge clk_i);
      lag(2);
    end
  endtask
  // reset for 16 cycles, then every scenario in turn
  initial begin
    err_total = 0;
    samples_checked = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, swap_active_i, core_sel_i} = 5'h00;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    marker_i = 1'h1;
    core_a_sample_i = 9'h1A5;
    core_b_sample_i = 9'h05A;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_reset();
    t_regs();
    t_link();
    t_marker();
    t_swap();
    conclude();
  end
endmodule
